// file: design/acrb_gain_decode.v
// Gain and amplifier bypass decode for the analog front end.
`timescale 1ns/1ps
`default_nettype none
`include "acrb_map.vh"
module acrb_gain_decode (
  input  wire [2:0] i_gain_code,   // Gain field, power of two
  input  wire       i_bypass_req,  // Requested amplifier bypass
  output wire [7:0] o_gain_onehot, // One-hot gain, bit n means gain 2**n
  output wire       o_amp_enable,  // Low-noise amplifier enabled
  output wire       o_sc_gain      // Gain taken by switched capacitors
);
  assign o_gain_onehot = 8'h01 << i_gain_code;
  assign o_amp_enable  = ~i_bypass_req | (i_gain_code > `ACRB_GAIN_MAX_BYPASS);
  assign o_sc_gain     = ~o_amp_enable;
endmodule
`default_nettype wire

// file: design/acrb_input_decode.v
// Input selector decode for the analog front end.
`timescale 1ns/1ps
`default_nettype none
`include "acrb_map.vh"
module acrb_input_decode (
  input  wire [3:0] i_sel,          // Input selector field
  output wire       o_differential, // Differential pair chosen
  output wire       o_single_ended, // Single input against negative supply
  output wire       o_ref_monitor,  // Quarter-scale reference monitor
  output wire       o_sup_monitor,  // Quarter-scale supply monitor
  output wire       o_shorted,      // Inputs shorted to mid-supply
  output wire       o_reserved      // Reserved code chosen
);
  assign o_differential = (i_sel < `ACRB_SEL_SINGLE_LO);
  assign o_single_ended = (i_sel >= `ACRB_SEL_SINGLE_LO) && (i_sel <= `ACRB_SEL_SINGLE_HI);
  assign o_ref_monitor  = (i_sel == `ACRB_SEL_REF_MON);
  assign o_sup_monitor  = (i_sel == `ACRB_SEL_SUP_MON);
  assign o_shorted      = (i_sel == `ACRB_SEL_SHORTED);
  assign o_reserved     = (i_sel == `ACRB_SEL_RESERVED);
endmodule
`default_nettype wire

// file: design/acrb_register_bank.v
// Configuration register bank of a delta-sigma converter.
// Functional notes
// - There are exactly five eight-bit registers, reached only by register read and write commands.
// - Power-up and every reset clear all bits of all five registers to zero.
// - Power-down leaves every register value untouched.
// - Registers sit at addresses 0 to 4 with selector/gain/bypass, rate/mode, flags, routing and pin fields.
// - Register 0 bits 7:4 choose differential pairs, single inputs, monitors, shorted input or reserved.
// - Register 0 bits 3:1 give gain two to the power of the code, 1 up to 128.
// - Gains 1, 2 and 4 may run with the amplifier bypassed, using switched capacitors.
// - Register 0 bit 0 at zero keeps the amplifier on, at one bypasses it.
// - Gain codes for 8 and above keep the amplifier on whatever the bypass bit says.
// - Reads of an empty address return zero and writes there are dropped.
// - A write to any register but address 4 pulses a filter reset and conversion restart.
`timescale 1ns/1ps
`default_nettype none
`include "acrb_map.vh"
module acrb_register_bank #(
  parameter ADDR_W = `ACRB_ADDR_W,
  parameter DATA_W = `ACRB_DATA_W
) (
  input  wire              I_REF_CLK,         // 10 MHz clock
  input  wire              I_SRST,            // Synchronous reset, high
  input  wire              I_POWER_DOWN,      // Power-down mode level
  input  wire              I_RD_STB,          // Register read command pulse
  input  wire              I_WR_STB,          // Register write command pulse
  input  wire [ADDR_W-1:0] I_ADDR,            // Register address
  input  wire [DATA_W-1:0] I_WDATA,           // Write data
  input  wire              I_RESULT_READY,    // Conversion result ready pulse
  input  wire              I_RESULT_TAKEN,    // Conversion data read pulse
  output reg  [DATA_W-1:0] O_RDATA,           // Read data
  output reg               O_RDATA_VALID,     // Read data valid pulse
  output reg               O_FILTER_RESTART,  // Filter reset and conversion restart pulse
  output reg  [3:0]        O_INPUT_SELECTOR,  // Input selector field
  output reg  [7:0]        O_GAIN_ONEHOT,     // One-hot gain
  output reg               O_AMP_ENABLE,      // Amplifier enabled
  output reg               O_SC_GAIN,         // Switched-capacitor gain active
  output reg               O_SEL_DIFF,        // Differential pair chosen
  output reg               O_SEL_SINGLE,      // Single-ended input chosen
  output reg               O_SEL_REF_MON,     // Reference monitor chosen
  output reg               O_SEL_SUP_MON,     // Supply monitor chosen
  output reg               O_SEL_SHORTED,     // Shorted input chosen
  output reg               O_SEL_RESERVED,    // Reserved selector chosen
  output reg  [DATA_W-1:0] O_RATE_MODE,       // Register 1 contents
  output reg  [DATA_W-1:0] O_FLAG_INTEG,      // Register 2 contents
  output reg  [DATA_W-1:0] O_CUR_ROUTE,       // Register 3 contents
  output reg  [DATA_W-1:0] O_PIN_IO           // Register 4 contents
);
  // ****************************************
  // Register storage
  // ****************************************
  reg  [DATA_W-1:0] input_gain_config_reg;
  reg  [DATA_W-1:0] rate_mode_config_reg;
  reg  [DATA_W-1:0] flag_integrity_current_config_reg;
  reg  [DATA_W-1:0] current_routing_config_reg;
  reg  [DATA_W-1:0] pin_io_config_reg;
  reg  [DATA_W-1:0] rdata_next;
  reg               ready_flag_next;
  wire [7:0]        gain_onehot;
  wire              amp_enable;
  wire              sc_gain;
  wire              sel_diff;
  wire              sel_single;
  wire              sel_ref;
  wire              sel_sup;
  wire              sel_short;
  wire              sel_res;
  // Address hits and qualified write strobes.
  wire              hit_reg0;
  wire              hit_reg1;
  wire              hit_reg2;
  wire              hit_reg3;
  wire              hit_reg4;
  wire              wr_reg0;
  wire              wr_reg1;
  wire              wr_reg2;
  wire              wr_reg3;
  wire              wr_reg4;

  // Compares the bus address with one register offset.
  function addr_match;
    input [ADDR_W-1:0] addr;
    input [ADDR_W-1:0] offset;
    begin
      addr_match = (addr == offset);
    end
  endfunction

  // Merges written bits into a register, keeping read-only positions.
  function [DATA_W-1:0] merge_write;
    input [DATA_W-1:0] old_val;
    input [DATA_W-1:0] new_val;
    input [DATA_W-1:0] wmask;
    begin
      merge_write = (old_val & ~wmask) | (new_val & wmask);
    end
  endfunction

  // ****************************************
  // Ready flag
  // ****************************************
  // Hardware sets the ready flag; a set in the clearing cycle wins.
  // The clear comes when the conversion data are read out.
  always @* begin
    ready_flag_next = flag_integrity_current_config_reg[`ACRB_READY_BIT];
    if (I_RESULT_TAKEN) begin
      ready_flag_next = 1'b0;
    end
    if (I_RESULT_READY) begin
      ready_flag_next = 1'b1;
    end
  end

  // ****************************************
  // Address decode
  // ****************************************
  // Each write strobe is qualified once here and shared by the register blocks; the read path compares I_ADDR on its own.
  // address decode
  assign hit_reg0 = addr_match(I_ADDR, `ACRB_ADDR_INPUT_GAIN);
  assign hit_reg1 = addr_match(I_ADDR, `ACRB_ADDR_RATE_MODE);
  assign hit_reg2 = addr_match(I_ADDR, `ACRB_ADDR_FLAG_INTEG);
  assign hit_reg3 = addr_match(I_ADDR, `ACRB_ADDR_CUR_ROUTE);
  assign hit_reg4 = addr_match(I_ADDR, `ACRB_ADDR_PIN_IO);

  // Addresses 5 to 7 hit no register, so no strobe rises for them.
  // unmapped write dropped
  assign wr_reg0  = I_WR_STB & hit_reg0;
  assign wr_reg1  = I_WR_STB & hit_reg1;
  assign wr_reg2  = I_WR_STB & hit_reg2;
  assign wr_reg3  = I_WR_STB & hit_reg3;
  assign wr_reg4  = I_WR_STB & hit_reg4;

  // ****************************************
  // Write path
  // ****************************************
  // Power-down gates nothing here, so contents persist through it.
  // Register 0 feeds the front-end decoders directly.
  // clear on reset
  always @(posedge I_REF_CLK) begin
    if (I_SRST) begin
      input_gain_config_reg <= `ACRB_RESET_VALUE;
    end else if (wr_reg0) begin
      input_gain_config_reg <= I_WDATA;
    end
  end

  // Register 1 fields pass through untouched.
  always @(posedge I_REF_CLK) begin
    if (I_SRST) begin
      rate_mode_config_reg <= `ACRB_RESET_VALUE;
    end else if (wr_reg1) begin
      rate_mode_config_reg <= I_WDATA;
    end
  end

  // The ready flag keeps its own next value, also when the other bits are written.
  always @(posedge I_REF_CLK) begin
    if (I_SRST) begin
      flag_integrity_current_config_reg <= `ACRB_RESET_VALUE;
    end else if (wr_reg2) begin
      flag_integrity_current_config_reg <= merge_write({ready_flag_next,
        flag_integrity_current_config_reg[6:0]}, I_WDATA, `ACRB_REG2_WMASK);
    end else begin
      flag_integrity_current_config_reg[`ACRB_READY_BIT] <= ready_flag_next;
    end
  end

  always @(posedge I_REF_CLK) begin
    if (I_SRST) begin
      current_routing_config_reg <= `ACRB_RESET_VALUE;
    end else if (wr_reg3) begin
      current_routing_config_reg <= merge_write(current_routing_config_reg, I_WDATA, `ACRB_REG3_WMASK);
    end
  end

  // Bit 7 of register 4 is fixed at zero and never stored.
  always @(posedge I_REF_CLK) begin
    if (I_SRST) begin
      pin_io_config_reg <= `ACRB_RESET_VALUE;
    end else if (wr_reg4) begin
      pin_io_config_reg <= merge_write(pin_io_config_reg, I_WDATA, `ACRB_REG4_WMASK);
    end
  end

  // Address 4 is left out, so pin writes leave a conversion running.
  // restart on write
  always @(posedge I_REF_CLK) begin
    if (I_SRST) begin
      O_FILTER_RESTART <= 1'b0;
    end else begin
      O_FILTER_RESTART <= wr_reg0 | wr_reg1 | wr_reg2 | wr_reg3;
    end
  end

  // ****************************************
  // Read path
  // ****************************************
  always @* begin
    // Reads see each stored value masked to its readable bits.
    // unmapped reads zero
    rdata_next = `ACRB_UNMAPPED_READ;
    if (I_ADDR == `ACRB_ADDR_INPUT_GAIN) begin
      rdata_next = input_gain_config_reg;
    end else if (I_ADDR == `ACRB_ADDR_RATE_MODE) begin
      rdata_next = rate_mode_config_reg;
    end else if (I_ADDR == `ACRB_ADDR_FLAG_INTEG) begin
      rdata_next = flag_integrity_current_config_reg;
    end else if (I_ADDR == `ACRB_ADDR_CUR_ROUTE) begin
      rdata_next = current_routing_config_reg & `ACRB_REG3_WMASK;
    end else if (I_ADDR == `ACRB_ADDR_PIN_IO) begin
      rdata_next = pin_io_config_reg & `ACRB_REG4_WMASK;
    end
  end

  // ****************************************
  // Read data register
  // ****************************************
  always @(posedge I_REF_CLK) begin
    if (I_SRST) begin
      O_RDATA       <= `ACRB_RESET_VALUE;
      O_RDATA_VALID <= 1'b0;
    end else begin
      O_RDATA_VALID <= I_RD_STB;
      if (I_RD_STB) begin
        O_RDATA <= rdata_next;
      end
    end
  end

  // ****************************************
  // Front-end decode
  // ****************************************
  // Gain and bypass decode for the amplifier.
  acrb_gain_decode u_gain (
    .i_gain_code   (input_gain_config_reg[`ACRB_GAIN_MSB:`ACRB_GAIN_LSB]),
    .i_bypass_req  (input_gain_config_reg[`ACRB_BYPASS_BIT]),
    .o_gain_onehot (gain_onehot),
    .o_amp_enable  (amp_enable),
    .o_sc_gain     (sc_gain)
  );

  // Input selector decode.
  acrb_input_decode u_input (
    .i_sel          (input_gain_config_reg[`ACRB_SEL_MSB:`ACRB_SEL_LSB]),
    .o_differential (sel_diff),
    .o_single_ended (sel_single),
    .o_ref_monitor  (sel_ref),
    .o_sup_monitor  (sel_sup),
    .o_shorted      (sel_short),
    .o_reserved     (sel_res)
  );

  // Decoded controls are registered so every output leaves a flip-flop.
  // selector out
  always @(posedge I_REF_CLK) begin
    if (I_SRST) begin
      O_INPUT_SELECTOR <= 4'h0;
      O_SEL_DIFF       <= 1'b1;
      O_SEL_SINGLE     <= 1'b0;
      O_SEL_REF_MON    <= 1'b0;
      O_SEL_SUP_MON    <= 1'b0;
      O_SEL_SHORTED    <= 1'b0;
      O_SEL_RESERVED   <= 1'b0;
    end else begin
      O_INPUT_SELECTOR <= input_gain_config_reg[`ACRB_SEL_MSB:`ACRB_SEL_LSB];
      O_SEL_DIFF       <= sel_diff;
      O_SEL_SINGLE     <= sel_single;
      O_SEL_REF_MON    <= sel_ref;
      O_SEL_SUP_MON    <= sel_sup;
      O_SEL_SHORTED    <= sel_short;
      O_SEL_RESERVED   <= sel_res;
    end
  end

  always @(posedge I_REF_CLK) begin
    if (I_SRST) begin
      O_GAIN_ONEHOT <= 8'h01;
      O_AMP_ENABLE  <= 1'b1;
      O_SC_GAIN     <= 1'b0;
    end else begin
      O_GAIN_ONEHOT <= gain_onehot;
      O_AMP_ENABLE  <= amp_enable;
      O_SC_GAIN     <= sc_gain;
    end
  end

  always @(posedge I_REF_CLK) begin
    if (I_SRST) begin
      O_RATE_MODE  <= `ACRB_RESET_VALUE;
      O_FLAG_INTEG <= `ACRB_RESET_VALUE;
      O_CUR_ROUTE  <= `ACRB_RESET_VALUE;
      O_PIN_IO     <= `ACRB_RESET_VALUE;
    end else begin
      O_RATE_MODE  <= rate_mode_config_reg;
      O_FLAG_INTEG <= flag_integrity_current_config_reg;
      O_CUR_ROUTE  <= current_routing_config_reg & `ACRB_REG3_WMASK;
      O_PIN_IO     <= pin_io_config_reg & `ACRB_REG4_WMASK;
    end
  end

endmodule
`default_nettype wire

// file: pkg/acrb_map.vh
// Register map constants for the converter configuration register bank.
`ifndef ACRB_MAP_VH
`define ACRB_MAP_VH
`define ACRB_ADDR_W          3
`define ACRB_DATA_W          8
`define ACRB_REG_COUNT       5
`define ACRB_ADDR_INPUT_GAIN 3'h0
`define ACRB_ADDR_RATE_MODE  3'h1
`define ACRB_ADDR_FLAG_INTEG 3'h2
`define ACRB_ADDR_CUR_ROUTE  3'h3
`define ACRB_ADDR_PIN_IO     3'h4
`define ACRB_RESET_VALUE     8'h00
`define ACRB_UNMAPPED_READ   8'h00
`define ACRB_SEL_MSB         7
`define ACRB_SEL_LSB         4
`define ACRB_GAIN_MSB        3
`define ACRB_GAIN_LSB        1
`define ACRB_BYPASS_BIT      0
`define ACRB_READY_BIT       7
`define ACRB_REG2_WMASK      8'h7f
`define ACRB_REG3_WMASK      8'hfd
`define ACRB_REG4_WMASK      8'h7f
`define ACRB_SEL_SINGLE_LO   4'h8
`define ACRB_SEL_SINGLE_HI   4'hb
`define ACRB_SEL_REF_MON     4'hc
`define ACRB_SEL_SUP_MON     4'hd
`define ACRB_SEL_SHORTED     4'he
`define ACRB_SEL_RESERVED    4'hf
`define ACRB_GAIN_MAX_BYPASS 3'h2
`endif

// file: verification/acrb_host_model.sv
// Host model issuing register read and write commands.
`timescale 1ns/1ps
`default_nettype none
module acrb_host_model (
  input  wire logic       clk,    // Clock
  input  wire logic [7:0] rdata,  // Read data
  input  wire logic       rvalid, // Read valid
  output var  logic       rd,     // Read command
  output var  logic       wr,     // Write command
  output var  logic [2:0] addr,   // Address
  output var  logic [7:0] wdata   // Write data
);
  // ********************************
  // Command tasks
  // ********************************
  initial begin
    rd = 1'b0;
    wr = 1'b0;
    addr = 3'h7;
    wdata = 8'hff;
  end
  task automatic write_reg(input logic [2:0] a, input logic [7:0] d);
    @(negedge clk);
    wr = 1'b1;
    addr = a;
    wdata = d;
    @(negedge clk);
    wr = 1'b0;
    addr = ~a;
    wdata = ~d;
  endtask
  task automatic read_reg(input logic [2:0] a, output logic [7:0] q, output logic v);
    @(negedge clk);
    rd = 1'b1;
    addr = a;
    @(negedge clk);
    rd = 1'b0;
    addr = ~a;
    q = rdata;
    v = rvalid;
  endtask
endmodule
`default_nettype wire

// file: verification/acrb_monitor.sv
// Concurrent checks on the register bank ports.
`timescale 1ns/1ps
`default_nettype none
module acrb_monitor (
  input wire logic       I_REF_CLK,        // Clock
  input wire logic       I_SRST,           // Reset
  input wire logic       I_RD_STB,         // Read
  input wire logic       I_WR_STB,         // Write
  input wire logic [2:0] I_ADDR,           // Address
  input wire logic [7:0] I_WDATA,          // Write data
  input wire logic [7:0] O_RDATA,          // Read data
  input wire logic       O_RDATA_VALID,    // Read valid
  input wire logic       O_FILTER_RESTART, // Restart
  input wire logic [3:0] O_INPUT_SELECTOR, // Selector
  input wire logic [7:0] O_GAIN_ONEHOT,    // Gain
  input wire logic       O_AMP_ENABLE,     // Amplifier on
  input wire logic       O_SC_GAIN,        // Capacitor gain
  input wire logic       O_SEL_DIFF,       // Differential
  input wire logic       O_SEL_SINGLE,     // Single-ended
  input wire logic       O_SEL_RESERVED,   // Reserved
  input wire logic [7:0] O_RATE_MODE,      // Register 1
  input wire logic [7:0] O_CUR_ROUTE,      // Register 3
  input wire logic [7:0] O_PIN_IO          // Register 4
);
  // ********************************
  // Port checks
  // ********************************
  default clocking cb @(posedge I_REF_CLK); endclocking
  default disable iff (I_SRST);
  property reg0_decode_p;
    logic [7:0] d;
    (I_WR_STB && I_ADDR == 3'h0, d = I_WDATA) |-> ##2 (O_INPUT_SELECTOR == d[7:4] &&
      O_GAIN_ONEHOT == (8'h01 << d[3:1]) && O_AMP_ENABLE == (!d[0] || d[3:1] > 3'h2));
  endproperty
  rvalid_timing_a: assert property (I_RD_STB |=> O_RDATA_VALID)
    else $error("read valid missing");
  rvalid_cause_a: assert property (O_RDATA_VALID |-> $past(I_RD_STB))
    else $error("read valid without read");
  unmapped_read_a: assert property (I_RD_STB && I_ADDR > 3'h4 |=> O_RDATA == 8'h00)
    else $error("unmapped read not zero");
  restart_write_a: assert property (I_WR_STB && I_ADDR < 3'h4 |=> O_FILTER_RESTART)
    else $error("restart missing");
  restart_cause_a: assert property (O_FILTER_RESTART |-> $past(I_WR_STB) && $past(I_ADDR) < 3'h4)
    else $error("restart without write");
  reg0_decode_a: assert property (reg0_decode_p)
    else $error("register 0 decode wrong");
  gain_onehot_a: assert property ($onehot(O_GAIN_ONEHOT))
    else $error("gain not one-hot");
  amp_forced_a: assert property (|O_GAIN_ONEHOT[7:3] |-> O_AMP_ENABLE)
    else $error("amplifier off at high gain");
  sc_gain_a: assert property (O_SC_GAIN != O_AMP_ENABLE && (!O_SC_GAIN || |O_GAIN_ONEHOT[2:0]))
    else $error("capacitor gain wrong");
  sel_decode_a: assert property (O_SEL_DIFF == !O_INPUT_SELECTOR[3] && O_SEL_RESERVED == &O_INPUT_SELECTOR
    && O_SEL_SINGLE == (O_INPUT_SELECTOR[3:2] == 2'b10)) else $error("selector decode wrong");
  fixed_zero_a: assert property (!O_CUR_ROUTE[1] && !O_PIN_IO[7])
    else $error("fixed bit not zero");
  reset_clear_a: assert property (disable iff (1'b0) I_SRST ##1 I_SRST |->
    O_RATE_MODE == 8'h00 && O_CUR_ROUTE == 8'h00 && O_PIN_IO == 8'h00) else $error("reset not clear");
  hold_value_a: assert property (!I_WR_STB [*2] |=> $stable(O_RATE_MODE) && $stable(O_PIN_IO))
    else $error("register changed without write");
  cover property (I_WR_STB && I_ADDR == 3'h0);
  cover property (I_RD_STB && I_ADDR > 3'h4);
  cover property (O_FILTER_RESTART);
  cover property (O_SC_GAIN);
endmodule
bind acrb_register_bank acrb_monitor mon (.I_REF_CLK, .I_SRST, .I_RD_STB, .I_WR_STB, .I_ADDR, .I_WDATA,
  .O_RDATA, .O_RDATA_VALID, .O_FILTER_RESTART, .O_INPUT_SELECTOR, .O_GAIN_ONEHOT, .O_AMP_ENABLE,
  .O_SC_GAIN, .O_SEL_DIFF, .O_SEL_SINGLE, .O_SEL_RESERVED, .O_RATE_MODE, .O_CUR_ROUTE, .O_PIN_IO);
`default_nettype wire

// file: verification/acrb_testbench.sv
// Self-checking testbench for the configuration register bank.
`timescale 1ns/1ps
`default_nettype none
module testbench;
  // ********************************
  // Stimulus and checks
  // ********************************
  logic       clk = 1'b0, srst = 1'b1, pd = 1'b0, rdy = 1'b0, tkn = 1'b0, v, rd, wr, rvalid, restart;
  logic       amp, sc, sdiff, ssing, sref, ssup, sshort, sres;
  logic [2:0] addr, a;
  logic [3:0] sel;
  logic [7:0] wdata, rdata, rmode, flag, croute, pinio, onehot, q, d;
  logic [7:0] shadow [0:4];
  logic [31:0] rnd;
  int         num_errors = 0, samples_checked = 0, seed = 70, i;
  acrb_host_model host (.clk(clk), .rdata(rdata), .rvalid(rvalid), .rd(rd), .wr(wr), .addr(addr), .wdata(wdata));
  acrb_register_bank dut (.I_REF_CLK(clk), .I_SRST(srst), .I_POWER_DOWN(pd), .I_RD_STB(rd), .I_WR_STB(wr),
    .I_ADDR(addr), .I_WDATA(wdata), .I_RESULT_READY(rdy), .I_RESULT_TAKEN(tkn), .O_RDATA(rdata),
    .O_RDATA_VALID(rvalid), .O_FILTER_RESTART(restart), .O_INPUT_SELECTOR(sel), .O_GAIN_ONEHOT(onehot),
    .O_AMP_ENABLE(amp), .O_SC_GAIN(sc), .O_SEL_DIFF(sdiff), .O_SEL_SINGLE(ssing), .O_SEL_REF_MON(sref),
    .O_SEL_SUP_MON(ssup), .O_SEL_SHORTED(sshort), .O_SEL_RESERVED(sres), .O_RATE_MODE(rmode),
    .O_FLAG_INTEG(flag), .O_CUR_ROUTE(croute), .O_PIN_IO(pinio));
  always #50 clk = ~clk;
  function automatic logic [7:0] wmask(input logic [2:0] x);
    return (x == 3'h3) ? 8'hfd : (x == 3'h2 || x == 3'h4) ? 8'h7f : 8'hff;
  endfunction
  function automatic logic [7:0] exp_decode(input logic [3:0] s);
    return {2'b00, !s[3], s[3:2] == 2'b10, s == 4'hc, s == 4'hd, s == 4'he, s == 4'hf};
  endfunction
  task automatic check(input string name, input logic [7:0] seen, input logic [7:0] exp);
    samples_checked++;
    if (seen !== exp) begin
      num_errors++;
      $display("[FAIL] %s expected %h seen %h", name, exp, seen);
    end
  endtask
  task automatic complete_run;
    $display("Checks %0d, mismatches %0d", samples_checked, num_errors);
    if (num_errors == 0 && samples_checked > 0) begin
      $display("ALL TESTS PASSED");
    end else begin
      $display("TESTS FAILED");
    end
    $finish;
  endtask
  task automatic read_all;
    for (int k = 0; k < 8; k++) begin
      host.read_reg(k[2:0], q, v);
      check("rdata", q, (k < 5) ? shadow[k] : 8'h00);
      check("rvalid", {7'h00, v}, 8'h01);
    end
    check("selector_mirror", {4'h0, sel}, {4'h0, shadow[0][7:4]});
    check("rate_mode", rmode, shadow[1]);
    check("flag_integ", flag, shadow[2]);
    check("cur_route", croute, shadow[3]);
    check("pin_io", pinio, shadow[4]);
  endtask
  // The run takes about 1800 cycles, so the limit leaves wide margin.
  initial begin
    #3000000;
    num_errors++;
    complete_run();
  end
  initial begin
    for (i = 0; i < 5; i++) shadow[i] = 8'h00;
    repeat (20) @(negedge clk);
    srst = 1'b0;
    read_all();
    repeat (60) begin
      rnd = $random(seed);
      a = rnd[2:0];
      d = rnd[15:8];
      pd = rnd[16];
      if (a == 3'h0) d[7] = 1'b0;
      host.write_reg(a, d);
      check("restart", {7'h00, restart}, {7'h00, a < 3'h4});
      if (a < 3'h5) shadow[a] = (d & wmask(a)) | (shadow[a] & ~wmask(a) & 8'h80);
      read_all();
    end
    @(negedge clk) rdy = 1'b1;
    @(negedge clk) rdy = 1'b0;
    shadow[2][7] = 1'b1;
    read_all();
    // A write to register 2 must leave the hardware flag alone.
    host.write_reg(3'h2, 8'h55);
    check("restart", {7'h00, restart}, 8'h01);
    shadow[2] = 8'hd5;
    read_all();
    @(negedge clk) tkn = 1'b1;
    @(negedge clk) tkn = 1'b0;
    shadow[2][7] = 1'b0;
    read_all();
    // Set and clear in one cycle: the set wins.
    @(negedge clk) begin
      rdy = 1'b1;
      tkn = 1'b1;
    end
    @(negedge clk) begin
      rdy = 1'b0;
      tkn = 1'b0;
    end
    shadow[2][7] = 1'b1;
    read_all();
    // A second reset in mid-run clears every register again.
    @(negedge clk) srst = 1'b1;
    repeat (3) @(negedge clk);
    srst = 1'b0;
    for (i = 0; i < 5; i++) shadow[i] = 8'h00;
    read_all();
    for (i = 0; i < 256; i++) begin
      d = i[7:0];
      // single inputs only bypassed at low gain.
      if (d[7:6] == 2'b10 && !(d[0] && d[3:1] <= 3'h2)) continue;
      host.write_reg(3'h0, d);
      @(negedge clk);
      check("selector", {4'h0, sel}, {4'h0, d[7:4]});
      check("gain", onehot, 8'h01 << d[3:1]);
      check("amp", {7'h00, amp}, {7'h00, !d[0] || d[3:1] > 3'h2});
      check("sc_gain", {7'h00, sc}, {7'h00, d[0] && d[3:1] <= 3'h2});
      check("decode", {2'b00, sdiff, ssing, sref, ssup, sshort, sres}, exp_decode(d[7:4]));
    end
    complete_run();
  end
endmodule
`default_nettype wire
